// >>> nmr_pkg.sv
// shared constants, types and helpers of the network master request port
package nmr_pkg;
  // apb register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_PORT_SLAVE = 12'h004;
  localparam logic [11:0] OFF_BYTE_COUNT = 12'h008;
  localparam logic [11:0] OFF_MASTER_ADDR = 12'h00C;
  localparam logic [11:0] OFF_CMD = 12'h010;
  localparam logic [11:0] OFF_STATUS = 12'h014;
  localparam logic [1:0] MEM_WINDOW_SEL = 2'h1;
  // field positions
  localparam int CTRL_NATIVE_BIT = 0;
  localparam int CTRL_OLD_FAMILY_BIT = 1;
  localparam int CMD_TYPE_LSB = 16;
  localparam int CMD_DIR_BIT = 24;
  localparam int CMD_AREA_LSB = 25;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  localparam int STAT_IGN_BIT = 2;
  localparam int STAT_CODE_LSB = 8;
  // reset values
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [15:0] PARAM_RESET = 16'h0000;
  // request encoding
  localparam logic [7:0] PORT_SEL_CODE = 8'hF1;
  localparam logic [7:0] MAX_SLAVE_MODBUS = 8'd99;
  localparam logic [7:0] MAX_SLAVE_NATIVE = 8'd90;
  localparam logic [9:0] MAX_BYTES = 10'd128;
  localparam logic [3:0] INREG_DIGIT = 4'h4;
  // function codes, frame lengths and crc constants on the wire
  localparam logic [7:0] FC_RD_COILS = 8'h01;
  localparam logic [7:0] FC_RD_INPUTS = 8'h02;
  localparam logic [7:0] FC_RD_HOLD = 8'h03;
  localparam logic [7:0] FC_RD_INREG = 8'h04;
  localparam logic [7:0] FC_WR_COILS = 8'h0F;
  localparam logic [7:0] FC_WR_REGS = 8'h10;
  localparam logic [7:0] NAT_RD = 8'h52;
  localparam logic [7:0] NAT_WR = 8'h57;
  localparam logic [7:0] RD_HDR_LEN = 8'd6;
  localparam logic [7:0] WR_HDR_LEN = 8'd7;
  localparam logic [7:0] WR_RSP_LEN = 8'd8;
  localparam logic [7:0] RD_RSP_OVERHEAD = 8'd5;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  // response timeout
  localparam longint RESP_TIMEOUT_MS = 800;
  localparam longint CLK_HZ = 125000000;
  localparam longint RESP_TIMEOUT_CYC = RESP_TIMEOUT_MS * CLK_HZ / 64'd1000;

  typedef enum logic [2:0] {
    NMR_DT_VMEM = 3'b000,
    NMR_DT_TCVAL = 3'b001,
    NMR_DT_INPUT = 3'b010,
    NMR_DT_OUTPUT = 3'b011,
    NMR_DT_SCRATCH = 3'b100,
    NMR_DT_DIAG = 3'b101
  } nmr_dtype_t;

  typedef enum logic [3:0] {
    NMR_E_NONE = 4'h0,
    NMR_E_PARAM = 4'h1,
    NMR_E_SLAVE = 4'h2,
    NMR_E_EXCEPT = 4'h3,
    NMR_E_FC = 4'h4,
    NMR_E_LEN = 4'h5,
    NMR_E_CRC = 4'h6,
    NMR_E_TIMEOUT = 4'h7
  } nmr_err_t;

  typedef enum logic [1:0] {
    NMR_IDLE = 2'b00,
    NMR_TX = 2'b01,
    NMR_RX = 2'b10
  } nmr_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } nmr_apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } nmr_apb_rsp_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } nmr_byte_t;

  // older-family point base to network base, octal values kept as binary
  function automatic logic [15:0] nmr_xlate(input logic [2:0] area, input logic [15:0] a);
    logic [15:0] pb;
    logic [15:0] mb;
    pb = 16'h0000;
    mb = 16'h0000;
    unique case (area)
      3'h0: begin pb = 16'h0180; mb = 16'h0000; end
      3'h1: begin pb = 16'h0000; mb = 16'h0000; end
      3'h2: begin pb = 16'h0100; mb = 16'h0040; end
      3'h3: begin pb = 16'h0180; mb = 16'h0180; end
      3'h4: begin pb = 16'h0070; mb = 16'h0070; end
      3'h5: begin pb = 16'h0100; mb = 16'h0100; end
      3'h6: begin pb = 16'h0000; mb = 16'h0080; end
      3'h7: begin pb = 16'h0000; mb = 16'h0000; end
    endcase
    return a - pb + mb;
  endfunction

  function automatic logic [15:0] nmr_crc(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
endpackage

// >>> nmr_request_port.sv
// network master request port: apb registers, frame engine and local memory
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ns
module nmr_request_port
  import nmr_pkg::*;
#(
  parameter int MEM_WORDS = 256,
  parameter longint TIMEOUT_CYC = RESP_TIMEOUT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire nmr_apb_req_t apb_req,
  output nmr_apb_rsp_t apb_rsp,
  output nmr_byte_t net_tx,
  input wire logic net_tx_ready,
  input wire nmr_byte_t net_rx,
  output logic port_busy_flag,
  output logic port_comm_error_flag
);
  localparam int AW = $clog2(MEM_WORDS);
  localparam logic [31:0] TO_LAST = 32'(TIMEOUT_CYC - 1);

  typedef struct packed {
    nmr_state_t st;
    logic busy;
    logic err;
    logic ignored;
    nmr_err_t code;
    logic [1:0] ctrl;
    logic [15:0] p_port;
    logic [15:0] p_count;
    logic [15:0] p_maddr;
    logic wr;
    logic [7:0] slave;
    logic [7:0] fc;
    logic [7:0] nbytes;
    logic [15:0] maddr;
    logic [15:0] saddr;
    logic [15:0] qty;
    logic [7:0] idx;
    logic [15:0] crc;
    logic [31:0] timer;
    logic wr_ok;
    nmr_byte_t tx;
    nmr_apb_rsp_t rsp;
  } nmr_regs_t;

  nmr_regs_t s_reg;
  nmr_regs_t s_next;
  logic [15:0] mem [MEM_WORDS];

  logic mem_we;
  logic mem_hi;
  logic [AW-1:0] mem_a;
  logic [7:0] mem_d;
  logic apb_mem_we;
  logic [AW-1:0] apb_mem_a;

  assign apb_rsp = s_reg.rsp;
  assign net_tx = s_reg.tx;
  assign port_busy_flag = s_reg.busy;
  assign port_comm_error_flag = s_reg.err;

  always_comb begin
    logic setup;
    logic fire;
    logic is_mem;
    logic [7:0] midx;
    logic mem_in;
    logic [31:0] rd;
    logic bad;
    logic native;
    logic wr;
    logic word_t;
    nmr_dtype_t dt;
    logic [3:0] sh;
    logic [3:0] sl;
    logic [7:0] slv;
    logic [9:0] cnt;
    logic ok;
    logic [7:0] fc;
    logic [15:0] qty;
    logic [16:0] span;
    logic [7:0] hdr_len;
    logic [7:0] k;
    logic [AW-1:0] ka;
    logic [15:0] w;
    logic [7:0] b;
    logic [15:0] c;
    logic [7:0] rlen;
    s_next = s_reg;
    mem_we = 1'b0;
    mem_hi = 1'b0;
    mem_a = '0;
    mem_d = 8'h00;
    apb_mem_we = 1'b0;
    apb_mem_a = '0;
    setup = apb_req.psel && !apb_req.penable;
    fire = apb_req.psel && apb_req.penable && s_reg.rsp.pready;
    is_mem = apb_req.paddr[11:10] == MEM_WINDOW_SEL;
    midx = apb_req.paddr[9:2];
    mem_in = 32'(midx) < MEM_WORDS;
    rd = 32'h00000000;
    c = 16'h0000;
    bad = 1'b0;
    native = s_reg.ctrl[CTRL_NATIVE_BIT];
    wr = apb_req.pwdata[CMD_DIR_BIT];
    dt = nmr_dtype_t'(apb_req.pwdata[CMD_TYPE_LSB +: 3]);
    word_t = (dt == NMR_DT_VMEM) || (dt == NMR_DT_TCVAL);
    sh = s_reg.p_port[7:4];
    sl = s_reg.p_port[3:0];
    slv = 8'((sh * 4'd10) + sl);
    cnt = 10'((s_reg.p_count[11:8] * 10'd100) + (s_reg.p_count[7:4] * 10'd10) + s_reg.p_count[3:0]);
    span = 17'(s_reg.p_maddr) + 17'((cnt + 10'd1) >> 1);

    // register reads and write acceptance decided in the setup cycle
    s_next.rsp.pready = 1'b0;
    if (setup) begin
      if (is_mem) begin
        bad = !mem_in || (apb_req.pwrite && s_reg.busy);
        rd = (mem_in && !apb_req.pwrite) ? {16'h0000, mem[AW'(midx)]} : 32'h00000000;
      end else begin
        unique case (apb_req.paddr)
          OFF_CTRL: rd = {30'h0, s_reg.ctrl};
          OFF_PORT_SLAVE: rd = {16'h0000, s_reg.p_port};
          OFF_BYTE_COUNT: rd = {16'h0000, s_reg.p_count};
          OFF_MASTER_ADDR: rd = {16'h0000, s_reg.p_maddr};
          OFF_CMD: rd = 32'h00000000;
          OFF_STATUS: begin
            rd[STAT_BUSY_BIT] = s_reg.busy;
            rd[STAT_ERR_BIT] = s_reg.err;
            rd[STAT_IGN_BIT] = s_reg.ignored;
            rd[STAT_CODE_LSB +: 4] = s_reg.code;
            bad = apb_req.pwrite;
          end
          default: bad = 1'b1;
        endcase
      end
      s_next.rsp.pready = 1'b1;
      s_next.rsp.prdata = apb_req.pwrite ? 32'h00000000 : rd;
      s_next.rsp.pslverr = bad;
      s_next.wr_ok = !bad;
    end

    // parameter writes refused while busy so the running transfer keeps them
    if (fire && apb_req.pwrite && s_reg.wr_ok && !s_reg.busy) begin
      if (is_mem) begin
        apb_mem_we = 1'b1;
        apb_mem_a = AW'(midx);
      end else begin
        unique case (apb_req.paddr)
          OFF_CTRL: s_next.ctrl = apb_req.pwdata[1:0];
          OFF_PORT_SLAVE: s_next.p_port = apb_req.pwdata[15:0];
          OFF_BYTE_COUNT: s_next.p_count = apb_req.pwdata[15:0];
          OFF_MASTER_ADDR: s_next.p_maddr = apb_req.pwdata[15:0];
          default: ;
        endcase
      end
    end

    // request command
    ok = 1'b0;
    fc = 8'h00;
    qty = 16'h0000;
    if (fire && apb_req.pwrite && s_reg.wr_ok && !is_mem && apb_req.paddr == OFF_CMD) begin
      if (s_reg.busy) begin
        s_next.ignored = 1'b1;
      end else begin
        s_next.ignored = 1'b0;
        s_next.err = 1'b0;
        s_next.code = NMR_E_NONE;
        native = s_reg.ctrl[CTRL_NATIVE_BIT];
        ok = (s_reg.p_port[15:8] == PORT_SEL_CODE)
          && (sh <= 4'd9) && (sl <= 4'd9) && (slv != 8'd0)
          && (slv <= (native ? MAX_SLAVE_NATIVE : MAX_SLAVE_MODBUS))
          && (s_reg.p_count[7:4] <= 4'd9) && (s_reg.p_count[3:0] <= 4'd9) && (s_reg.p_count[11:8] <= 4'd9)
          && (cnt != 10'd0) && (cnt <= MAX_BYTES)
          && (s_reg.p_count[15:12] == 4'h0
            || (s_reg.p_count[15:12] == INREG_DIGIT && !wr && !native && word_t))
          && (!word_t || !cnt[0])
          && (dt <= NMR_DT_DIAG)
          && (32'(span) <= MEM_WORDS);
        if (native) begin
          fc = wr ? NAT_WR : NAT_RD;
          qty = 16'(cnt);
        end else if (word_t) begin
          fc = wr ? FC_WR_REGS : ((s_reg.p_count[15:12] == INREG_DIGIT) ? FC_RD_INREG : FC_RD_HOLD);
          qty = 16'(cnt >> 1);
        end else begin
          fc = wr ? FC_WR_COILS : ((dt == NMR_DT_INPUT) ? FC_RD_INPUTS : FC_RD_COILS);
          qty = 16'(cnt) << 3;
        end
        if (ok) begin
          s_next.st = NMR_TX;
          s_next.busy = 1'b1;
          s_next.wr = wr;
          s_next.slave = slv;
          s_next.fc = fc;
          s_next.nbytes = cnt[7:0];
          s_next.maddr = s_reg.p_maddr;
          s_next.qty = qty;
          // same-family and native slaves take their own address as is
          s_next.saddr = (s_reg.ctrl[CTRL_OLD_FAMILY_BIT] && !native)
            ? nmr_xlate(apb_req.pwdata[CMD_AREA_LSB +: 3], apb_req.pwdata[15:0])
            : apb_req.pwdata[15:0];
          s_next.idx = 8'h00;
          s_next.crc = CRC_INIT;
        end else begin
          s_next.err = 1'b1;
          s_next.code = NMR_E_PARAM;
        end
      end
    end

    // frame engine
    hdr_len = s_reg.wr ? WR_HDR_LEN : RD_HDR_LEN;
    k = s_reg.idx - hdr_len;
    ka = AW'(s_reg.maddr) + AW'(k[7:1]);
    w = mem[ka];
    b = 8'h00;
    rlen = s_reg.wr ? WR_RSP_LEN : 8'(s_reg.nbytes + RD_RSP_OVERHEAD);
    unique case (s_reg.st)
      NMR_IDLE: begin
        s_next.tx.valid = 1'b0;
      end
      NMR_TX: begin
        // rtu layout: station, function, address, quantity, [count, data], crc low, crc high
        if (s_reg.idx == 8'd0) b = s_reg.slave;
        else if (s_reg.idx == 8'd1) b = s_reg.fc;
        else if (s_reg.idx == 8'd2) b = s_reg.saddr[15:8];
        else if (s_reg.idx == 8'd3) b = s_reg.saddr[7:0];
        else if (s_reg.idx == 8'd4) b = s_reg.qty[15:8];
        else if (s_reg.idx == 8'd5) b = s_reg.qty[7:0];
        else if (s_reg.wr && s_reg.idx == 8'd6) b = s_reg.nbytes;
        else if (s_reg.wr && k < s_reg.nbytes) b = k[0] ? w[15:8] : w[7:0];
        else if (s_reg.wr ? (k == s_reg.nbytes) : (s_reg.idx == RD_HDR_LEN)) b = s_reg.crc[7:0];
        else b = s_reg.crc[15:8];
        s_next.tx.valid = 1'b1;
        s_next.tx.data = b;
        if (s_reg.tx.valid && net_tx_ready) begin
          // crc bytes themselves never feed the running crc
          if (s_reg.wr ? (k >= s_reg.nbytes && s_reg.idx >= WR_HDR_LEN) : (s_reg.idx >= RD_HDR_LEN)) begin
            if (s_reg.tx.data == s_reg.crc[15:8] && (s_reg.wr ? (k == 8'(s_reg.nbytes + 8'd1))
                : (s_reg.idx == 8'(RD_HDR_LEN + 8'd1)))) begin
              s_next.tx.valid = 1'b0;
              s_next.st = NMR_RX;
              s_next.idx = 8'h00;
              s_next.crc = CRC_INIT;
              s_next.timer = 32'h00000000;
            end else begin
              s_next.idx = s_reg.idx + 8'd1;
              s_next.tx.data = s_reg.crc[15:8];
            end
          end else begin
            s_next.idx = s_reg.idx + 8'd1;
            s_next.crc = nmr_crc(s_reg.crc, s_reg.tx.data);
            // byte taken: fold it into the crc and drop valid for one cycle before the next byte
            s_next.tx.valid = 1'b0;
          end
        end else if (s_reg.tx.valid) begin
          s_next.tx = s_reg.tx;
        end
      end
      NMR_RX: begin
        s_next.timer = s_reg.timer + 32'd1;
        if (net_rx.valid) begin
          s_next.timer = 32'h00000000;
          c = nmr_crc(s_reg.crc, net_rx.data);
          s_next.crc = c;
          s_next.idx = s_reg.idx + 8'd1;
          if (s_reg.idx == 8'd0 && net_rx.data != s_reg.slave) begin
            s_next.code = NMR_E_SLAVE;
            s_next.err = 1'b1;
          end else if (s_reg.idx == 8'd1 && net_rx.data[7]) begin
            s_next.code = NMR_E_EXCEPT;
            s_next.err = 1'b1;
          end else if (s_reg.idx == 8'd1 && net_rx.data != s_reg.fc) begin
            s_next.code = NMR_E_FC;
            s_next.err = 1'b1;
          end else if (!s_reg.wr && s_reg.idx == 8'd2 && net_rx.data != s_reg.nbytes) begin
            s_next.code = NMR_E_LEN;
            s_next.err = 1'b1;
          end else if (s_reg.idx == rlen - 8'd1) begin
            if (c != 16'h0000) begin
              s_next.code = NMR_E_CRC;
              s_next.err = 1'b1;
            end
            s_next.st = NMR_IDLE;
            s_next.busy = 1'b0;
          end
          if (!s_reg.wr && s_reg.idx >= 8'd3 && s_reg.idx < 8'(s_reg.nbytes + 8'd3)) begin
            // byte lanes: an odd last byte leaves the upper half alone
            mem_we = 1'b1;
            mem_hi = s_reg.idx[0] == 1'b0;
            mem_a = AW'(s_reg.maddr) + AW'(8'(s_reg.idx - 8'd3) >> 1);
            mem_d = net_rx.data;
          end
          if (s_next.err && s_reg.idx < rlen - 8'd1) begin
            s_next.st = NMR_IDLE;
            s_next.busy = 1'b0;
          end
        end else if (s_reg.timer == TO_LAST) begin
          s_next.code = NMR_E_TIMEOUT;
          s_next.err = 1'b1;
          s_next.st = NMR_IDLE;
          s_next.busy = 1'b0;
        end
      end
      default: begin
        s_next.st = NMR_IDLE;
        s_next.busy = 1'b0;
        s_next.tx.valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '{st: NMR_IDLE, busy: 1'b0, err: 1'b0, ignored: 1'b0, code: NMR_E_NONE, ctrl: CTRL_RESET,
        p_port: PARAM_RESET, p_count: PARAM_RESET, p_maddr: PARAM_RESET, wr: 1'b0, slave: 8'h00,
        fc: 8'h00, nbytes: 8'h00, maddr: 16'h0000, saddr: 16'h0000, qty: 16'h0000, idx: 8'h00,
        crc: CRC_INIT, timer: 32'h00000000, wr_ok: 1'b0, tx: '0, rsp: '0};
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // local memory, engine and bus never write in the same cycle: bus writes are refused while busy
  always_ff @(posedge pclk) begin
    if (ce) begin
      if (mem_we && mem_hi) begin
        mem[mem_a][15:8] <= mem_d;
      end else if (mem_we) begin
        mem[mem_a][7:0] <= mem_d;
      end else if (apb_mem_we) begin
        mem[apb_mem_a] <= apb_req.pwdata[15:0];
      end
    end
  end
endmodule

// >>> nmr_port_monitor.sv
// assertion checker for the network master request port
`timescale 1ns/1ns
module nmr_port_monitor
  import nmr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire nmr_apb_req_t apb_req,
  input wire nmr_apb_rsp_t apb_rsp,
  input wire nmr_byte_t net_tx,
  input wire logic net_tx_ready,
  input wire nmr_byte_t net_rx,
  input wire logic port_busy_flag,
  input wire logic port_comm_error_flag
);
  logic cmd_w;
  logic setup_w;
  assign cmd_w = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready && apb_req.paddr == OFF_CMD;
  assign setup_w = ce && apb_req.psel && !apb_req.penable;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence start_s;
    cmd_w && !port_busy_flag;
  endsequence
  sequence offer_s;
    net_tx.valid && !net_tx_ready;
  endsequence
  apb_answer_a: assert property (setup_w |=> apb_rsp.pready ##1 !apb_rsp.pready)
    else $error("apb answer not a single cycle");
  unmapped_err_a: assert property (setup_w && apb_req.paddr[11:10] == 2'h0 && apb_req.paddr > OFF_STATUS
    |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0) else $error("unmapped access not refused");
  tx_hold_a: assert property (offer_s |=> net_tx.valid && $stable(net_tx.data))
    else $error("tx byte dropped before taken");
  tx_busy_a: assert property (net_tx.valid |-> ##[0:1] port_busy_flag)
    else $error("tx traffic without busy");
  cmd_start_a: assert property (start_s |=> port_busy_flag || port_comm_error_flag)
    else $error("command neither started nor refused");
  idle_hold_a: assert property (!port_busy_flag && !cmd_w |=> !port_busy_flag)
    else $error("busy rose without a command");
  busy_ignore_a: assert property (port_busy_flag && cmd_w && !net_rx.valid |=> port_busy_flag)
    else $error("command while busy disturbed transfer");
  err_fall_a: assert property ($fell(port_comm_error_flag) |-> $past(cmd_w))
    else $error("error cleared without a command");
  err_idle_a: assert property (port_comm_error_flag |-> !port_busy_flag)
    else $error("error flag while busy");
endmodule
bind nmr_request_port nmr_port_monitor mon_u (.pclk(pclk), .presetn(presetn), .ce(ce), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .net_tx(net_tx), .net_tx_ready(net_tx_ready), .net_rx(net_rx),
  .port_busy_flag(port_busy_flag), .port_comm_error_flag(port_comm_error_flag));

// >>> nmr_slave_model.sv
// behavioural slave station on the far side of the request port
`timescale 1ns/1ns
module nmr_slave_model
  import nmr_pkg::*;
(
  input wire logic pclk,
  input wire nmr_byte_t net_tx,
  output logic net_tx_ready,
  output nmr_byte_t net_rx,
  input wire logic slow,
  input wire logic bad,
  input wire logic mute
);
  logic [7:0] frm [0:140];
  logic [7:0] rsp [0:140];
  logic [15:0] txres;
  logic [15:0] c;
  int idx;
  int len;
  int n;
  function automatic logic [15:0] crc16(input logic [15:0] v, input logic [7:0] b);
    v = v ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      v = v[0] ? (v >> 1) ^ 16'hA001 : v >> 1;
    end
    return v;
  endfunction
  // speaks only after a whole request: a slave never opens traffic
  initial begin
    net_tx_ready = 1'b0;
    net_rx = '0;
    forever begin
      idx = 0;
      len = 8;
      while (idx < len) begin
        @(posedge pclk);
        if (net_tx.valid && net_tx_ready) begin
          frm[idx] = net_tx.data;
          idx++;
          if (idx == 7 && frm[1] inside {FC_WR_COILS, FC_WR_REGS, NAT_WR}) len = 9 + frm[6];
        end
        net_tx_ready <= slow ? !net_tx_ready : 1'b1;
      end
      c = 16'hFFFF;
      for (int k = 0; k < len; k++) c = crc16(c, frm[k]);
      txres = c;
      n = {frm[4], frm[5]};
      n = frm[1] < 3 ? (n + 7) / 8 : frm[1] < 5 ? n * 2 : n;
      rsp[0] = frm[0];
      rsp[1] = frm[1];
      rsp[2] = n[7:0];
      for (int k = 0; k < n; k++) rsp[3 + k] = 8'(8'h11 * (k + 1));
      // a write is answered by echoing its six header bytes
      if (len > 8) begin
        for (int k = 0; k < 6; k++) rsp[k] = frm[k];
        n = 3;
      end
      len = n + 3;
      c = 16'hFFFF;
      for (int k = 0; k < len; k++) c = crc16(c, rsp[k]);
      rsp[len] = c[7:0] ^ {7'h00, bad};
      rsp[len + 1] = c[15:8];
      // idle data is inverted so a stale byte can never pass for a fresh one
      // a muted station swallows the request so the port has to time out
      for (int k = 0; k < (mute ? 0 : len + 2); k++) begin
        @(posedge pclk);
        net_rx <= '{1'b1, rsp[k]};
        @(posedge pclk);
        net_rx <= '{1'b0, ~rsp[k]};
      end
    end
  end
endmodule

// >>> nmr_request_port_tb_top.sv
// self-checking bench of the network master request port
`timescale 1ns/1ns
module nmr_request_port_tb_top import nmr_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic slow = 1'b0;
  logic bad = 1'b0;
  logic mute = 1'b0;
  nmr_apb_req_t apb_req = '0;
  nmr_apb_rsp_t apb_rsp;
  nmr_byte_t net_tx;
  logic net_tx_ready;
  nmr_byte_t net_rx;
  logic port_busy_flag;
  logic port_comm_error_flag;
  logic [31:0] r;
  logic e;
  int err_total = 0;
  int comparisons = 0;
  // short response timeout keeps a lost answer cheap in simulation
  nmr_request_port #(.MEM_WORDS(256), .TIMEOUT_CYC(200)) dut_u (.pclk(pclk), .presetn(presetn), .ce(ce),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .net_tx(net_tx), .net_tx_ready(net_tx_ready), .net_rx(net_rx),
    .port_busy_flag(port_busy_flag), .port_comm_error_flag(port_comm_error_flag));
  nmr_slave_model slv_u (.pclk(pclk), .net_tx(net_tx), .net_tx_ready(net_tx_ready), .net_rx(net_rx),
    .slow(slow), .bad(bad), .mute(mute));
  always #4 pclk = ~pclk;
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rv,
    output logic ev);
    int t;
    t = 0;
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (apb_rsp.pready !== 1'b1 && t < 50);
    chk("pready", t < 50, 1);
    rv = apb_rsp.prdata;
    ev = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0, r, e);
  endtask
  task automatic st(input logic [31:0] x);
    rd(OFF_STATUS);
    chk("status", r & 32'hF03, x);
  endtask
  task automatic req(input logic [15:0] p, input logic [15:0] n, input logic [15:0] ma, input logic [31:0] cmd);
    wr(OFF_PORT_SLAVE, {16'h0, p});
    wr(OFF_BYTE_COUNT, {16'h0, n});
    wr(OFF_MASTER_ADDR, {16'h0, ma});
    wr(OFF_CMD, cmd);
  endtask
  task automatic idle();
    int t;
    t = 0;
    while (port_busy_flag !== 1'b0 && t < 9000) begin
      @(posedge pclk);
      t++;
    end
    chk("done", t < 9000, 1);
  endtask
  function automatic logic [31:0] fb(input int i);
    return {slv_u.frm[i], slv_u.frm[i + 1], slv_u.frm[i + 2], slv_u.frm[i + 3]};
  endfunction
  task automatic t_regs();
    rd(OFF_CTRL);
    chk("ctrl", r, CTRL_RESET);
    rd(OFF_PORT_SLAVE);
    chk("param", r, PARAM_RESET);
    wr(OFF_CTRL, 32'h3);
    rd(OFF_CTRL);
    chk("ctrl", r, 32'h3);
    apb(1'b0, 12'h018, 32'h0, r, e);
    chk("unmapped", {r[30:0], e}, 32'h1);
    apb(1'b1, OFF_STATUS, 32'h1, r, e);
    chk("ro", e, 1);
    wr(OFF_CTRL, 32'h0);
  endtask
  // each row breaks one field of the request; all must be refused
  task automatic t_bad();
    logic [15:0] p [7] = '{16'hF205, 16'hF100, 16'hF19A, 16'hF191, 16'hF105, 16'hF105, 16'hF105};
    logic [15:0] n [7] = '{16'h0002, 16'h0002, 16'h0002, 16'h0002, 16'h0129, 16'h0003, 16'h0000};
    for (int i = 0; i < 7; i++) begin
      wr(OFF_CTRL, {31'h0, i == 3});
      req(p[i], n[i], 16'h0, 32'h0);
      st(32'h102);
    end
    wr(OFF_CTRL, 32'h0);
  endtask
  task automatic t_read();
    wr(12'h444, 32'hCD00);
    req(16'hF105, 16'h0003, 16'h0010, 32'h0003_0040);
    chk("busy", port_busy_flag, 1);
    chk("err", port_comm_error_flag, 0);
    idle();
    chk("hdr", fb(0), {8'h05, FC_RD_COILS, 16'h0040});
    chk("qty", fb(4) >> 16, 24);
    chk("crc", slv_u.txres, 0);
    rd(12'h440);
    chk("mem", r, 32'h2211);
    rd(12'h444);
    chk("mem", r, 32'hCD33);
    st(32'h0);
  endtask
  task automatic t_write();
    slow <= 1'b1;
    wr(12'h480, 32'h1234);
    wr(12'h484, 32'h5678);
    req(16'hF107, 16'h0004, 16'h0020, 32'h0100_0100);
    wr(OFF_CMD, 32'h0003_0040);
    apb(1'b1, 12'h480, 32'h9999, r, e);
    chk("slverr", e, 1);
    rd(OFF_STATUS);
    chk("ignored", r[2:0], 3'b101);
    idle();
    chk("hdr", fb(0), {8'h07, FC_WR_REGS, 16'h0100});
    chk("cnt", fb(4) >> 8, 32'h0204);
    chk("data", fb(7), 32'h3412_7856);
    chk("crc", slv_u.txres, 0);
    repeat (20) @(posedge pclk);
    chk("busy", port_busy_flag, 0);
    slow <= 1'b0;
  endtask
  task automatic t_inreg();
    wr(OFF_CTRL, 32'h2);
    bad <= 1'b1;
    req(16'hF103, 16'h4002, 16'h0040, 32'h0001_0185);
    idle();
    chk("hdr", fb(0), {8'h03, FC_RD_INREG, 16'h0005});
    chk("qty", fb(4) >> 16, 1);
    st(32'h602);
    bad <= 1'b0;
  endtask
  task automatic t_native();
    wr(OFF_CTRL, 32'h1);
    req(16'hF190, 16'h0002, 16'h0030, 32'h0000_0400);
    idle();
    chk("hdr", fb(0), {8'd90, NAT_RD, 16'h0400});
    rd(12'h4C0);
    chk("mem", r, 32'h2211);
    st(32'h0);
  endtask
  task automatic t_mute();
    wr(OFF_CTRL, 32'h0);
    mute <= 1'b1;
    req(16'hF105, 16'h0002, 16'h0050, 32'h0000_0010);
    idle();
    chk("hdr", fb(0), {8'h05, FC_RD_HOLD, 16'h0010});
    st(32'h702);
    mute <= 1'b0;
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_bad();
    t_read();
    t_write();
    t_inreg();
    t_native();
    t_mute();
    results();
  end
  // the whole run needs under a thousand cycles; this cuts a hang
  initial begin
    #200000;
    err_total++;
    results();
  end
endmodule
